//--- bench/tsrp_port_assertions.sv
// Concurrent checks on the pins of the sensor register port
`include "tsrp_consts.svh"
module tsrp_port_checker #(
  parameter int TIMEOUT_CYC = `TSRP_TIMEOUT_CYC
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link clock and pins
  input wire logic sclClk,
  input wire tsrp_pkg::tsrp_bus_in_t busIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Conversion engine
  input wire tsrp_pkg::tsrp_readings_t readings,
  input wire logic readingsStrobe,
  input wire logic converting,
  input wire logic standby,
  input wire logic oneShotGo,
  input wire logic [7:0] configOut,
  input wire logic [7:0] filterOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Bus low time, raw lines so sync delay needs a small margin
  // ----------------------------------------------------------------
  logic [31:0] sclLowCnt;
  logic [31:0] sdaLowCnt;
  logic [31:0] next_sclLowCnt;
  logic [31:0] next_sdaLowCnt;
  logic stuckLong;
  assign next_sclLowCnt = busIn.sclIn ? 32'h0 : sclLowCnt + 32'h1;
  assign next_sdaLowCnt = busIn.sdaIn ? 32'h0 : sdaLowCnt + 32'h1;
  assign stuckLong = (sclLowCnt > TIMEOUT_CYC + 8) ||
                     (sdaLowCnt > TIMEOUT_CYC + 8);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclLowCnt <= 32'h0;
      sdaLowCnt <= 32'h0;
    end else begin
      sclLowCnt <= next_sclLowCnt;
      sdaLowCnt <= next_sdaLowCnt;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sda_low_only_a: assert property (!sdaOut)
    else $error("data pin output not low");
  oe_clk_low_a: assert property (
    $rose(sdaOe) |-> !busIn.sclIn && !$past(busIn.sclIn))
    else $error("data drive began while clock high");
  oe_hold_a: assert property (
    busIn.sclIn && $past(busIn.sclIn, 3) |-> $stable(sdaOe))
    else $error("data drive changed while clock high");
  start_release_a: assert property (
    $fell(busIn.sdaIn) && busIn.sclIn |=> !sdaOe [*8])
    else $error("data driven right after a start");
  timeout_idle_a: assert property (
    stuckLong |-> !sdaOe)
    else $error("data still driven after bus timeout");
  shot_pulse_a: assert property (
    $rose(oneShotGo) |=> !oneShotGo [*8])
    else $error("one-shot request longer than one cycle");
  shot_standby_a: assert property (oneShotGo |-> standby)
    else $error("one-shot request outside standby");
  standby_cfg_a: assert property (
    standby == configOut[`TSRP_CFG_STANDBY])
    else $error("standby differs from its control bit");
  reset_vals_a: assert property ($rose(rst_n) |->
    filterOut == `TSRP_FILTER_RST && configOut == `TSRP_CONFIG_RST)
    else $error("control registers not at reset value");

  shot_c: cover property (oneShotGo);
  ack_c: cover property ($rose(sdaOe));
  timeout_c: cover property (stuckLong);
endmodule : tsrp_port_checker

bind tsrp_port tsrp_port_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_checker (
  .clk(clk), .rst_n(rst_n), .sclClk(sclClk), .busIn(busIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .readings(readings),
  .readingsStrobe(readingsStrobe), .converting(converting),
  .standby(standby), .oneShotGo(oneShotGo), .configOut(configOut),
  .filterOut(filterOut));

//--- bench/tsrp_port_tb.sv
// Self-checking bench of the sensor register port
`include "tsrp_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tsrp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] flt;
    logic [7:0] ptr;
    tsrp_pkg::tsrp_readings_t rd;
    logic [15:0] exp;
  } tsrp_row_t;

  logic clk, sclClk, rst_n, readingsStrobe, converting, scl, sdaLow, ack;
  logic sdaOut, sdaOe, standby, oneShotGo;
  logic [7:0] configOut, filterOut, d, curCfg, curFlt;
  tsrp_pkg::tsrp_readings_t readings;
  tsrp_pkg::tsrp_bus_in_t busIn;
  wire logic sdaLine = !(sdaOe || sdaLow);
  int n_fail = 0;
  int checks = 0;
  int shots = 0;
  tsrp_row_t rows[10];
  assign busIn = {scl, sdaLine};

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // Link clock, phase unrelated to the system clock
  initial begin
    sclClk = 1'b0;
    #3.7;
    forever #62.5 sclClk = !sclClk;
  end

  // Short timeout keeps recovery quick, yet outlasts a byte of zeros
  tsrp_port #(.TIMEOUT_CYC(1000)) u_dut (.clk(clk), .rst_n(rst_n),
    .sclClk(sclClk), .busIn(busIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .readings(readings), .readingsStrobe(readingsStrobe),
    .converting(converting), .standby(standby), .oneShotGo(oneShotGo),
    .configOut(configOut), .filterOut(filterOut));
  tsrp_smbus_master u_master (.sclClk(sclClk), .sdaLine(sdaLine),
    .scl(scl), .sdaLow(sdaLow));

  always @(posedge clk) if (oneShotGo === 1'b1) shots++;

  function automatic tsrp_row_t mk(input logic [7:0] c, f, p,
      input logic [9:0] l, input logic [12:0] r1, r2,
      input logic [2:0] fl, input logic [15:0] e);
    mk = {c, f, p, l, r1, r2, fl, e};
  endfunction : mk

  task automatic setRd(input tsrp_pkg::tsrp_readings_t r, input logic cv);
    @(negedge clk);
    readings = r;
    converting = cv;
    readingsStrobe = 1'b1;
    @(negedge clk);
    readingsStrobe = 1'b0;
  endtask : setRd

  task automatic wr(input logic [7:0] p, input logic [7:0] v, input bit dat);
    u_master.start();
    u_master.put({`TSRP_SLAVE_ADDR, 1'b0}, ack);
    `CHK(ack, 1'b0)
    u_master.put(p, ack);
    if (dat) u_master.put(v, ack);
    u_master.stop();
  endtask : wr

  task automatic rd(input logic [7:0] p, input bit cmd, output logic [7:0] v);
    if (cmd) begin
      u_master.start();
      u_master.put({`TSRP_SLAVE_ADDR, 1'b0}, ack);
      u_master.put(p, ack);
    end
    u_master.start();
    u_master.put({`TSRP_SLAVE_ADDR, 1'b1}, ack);
    `CHK(ack, 1'b0)
    u_master.get(1'b1, v);
    u_master.stop();
  endtask : rd

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  initial begin
    #950us;
    n_fail++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    readings = '0;
    readingsStrobe = 1'b0;
    converting = 1'b0;
    curCfg = 8'h00;
    curFlt = 8'h05;
    rows[0] = mk(8'h00, 8'h05, 8'h10, 10'h064, 13'h0, 13'h0, 3'h0, 16'h1900);
    rows[1] = mk(8'h00, 8'h05, 8'h10, 10'h3FF, 13'h0, 13'h0, 3'h0, 16'hFFC0);
    rows[2] = mk(8'h00, 8'h05, 8'h10, 10'h200, 13'h0, 13'h0, 3'h1, 16'h7FC0);
    rows[3] = mk(8'h00, 8'h05, 8'h11, 10'h0, 13'h0001, 13'h0, 3'h0, 16'h0008);
    rows[4] = mk(8'h00, 8'h05, 8'h11, 10'h0, 13'h1CE0, 13'h0, 3'h0, 16'hE700);
    rows[5] = mk(8'h00, 8'h00, 8'h12, 10'h0, 13'h0, 13'h0007, 3'h0, 16'h0020);
    rows[6] = mk(8'h10, 8'h00, 8'h12, 10'h0, 13'h0, 13'h1920, 3'h0, 16'hC900);
    rows[7] = mk(8'h00, 8'h00, 8'h11, 10'h0, 13'h0320, 13'h0, 3'h4, 16'h8000);
    rows[8] = mk(8'h10, 8'h00, 8'h12, 10'h0, 13'h0, 13'h0320, 3'h2, 16'hFFE0);
    rows[9] = mk(8'h10, 8'h04, 8'h12, 10'h0, 13'h0, 13'h0320, 3'h2, 16'hFFE0);
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    setRd({10'h064, 13'h0, 13'h0, 3'h0}, 1'b0);
    rd(8'h00, 1'b0, d);
    `CHK(d, 8'h19)
    foreach (rows[i]) begin
      if (rows[i].cfg !== curCfg) wr(8'h03, rows[i].cfg, 1'b1);
      if (rows[i].flt !== curFlt) wr(8'h06, rows[i].flt, 1'b1);
      curCfg = rows[i].cfg;
      curFlt = rows[i].flt;
      setRd(rows[i].rd, 1'b0);
      rd(rows[i].ptr, 1'b1, d);
      `CHK(d, rows[i].exp[15:8])
      rd(rows[i].ptr + 8'h10, 1'b1, d);
      `CHK(d, rows[i].exp[7:0])
    end
    // Low byte coherency across two high byte reads
    wr(8'h06, 8'h05, 1'b1);
    `CHK(filterOut, 8'h05)
    setRd({10'h0, 13'h0001, 13'h0, 3'h0}, 1'b0);
    rd(8'h11, 1'b1, d);
    setRd({10'h0, 13'h0322, 13'h0, 3'h0}, 1'b0);
    rd(8'h11, 1'b1, d);
    `CHK(d, 8'h19)
    setRd({10'h0, 13'h0001, 13'h0, 3'h0}, 1'b0);
    rd(8'h21, 1'b1, d);
    `CHK(d, 8'h10)
    rd(8'h21, 1'b1, d);
    `CHK(d, 8'h08)
    // Status flags, then pointer kept and start abort
    setRd({10'h0, 13'h0, 13'h0, 3'h2}, 1'b1);
    rd(8'h02, 1'b1, d);
    `CHK(d, 8'h82)
    setRd({10'h0, 13'h0, 13'h0, 3'h4}, 1'b0);
    rd(8'h02, 1'b1, d);
    `CHK(d, 8'h01)
    rd(8'h00, 1'b0, d);
    `CHK(d, 8'h01)
    u_master.start();
    u_master.put({`TSRP_SLAVE_ADDR, 1'b0}, ack);
    rd(8'h00, 1'b0, d);
    `CHK(d, 8'h01)
    u_master.start();
    u_master.put({`TSRP_SLAVE_ADDR ^ 7'h01, 1'b1}, ack);
    `CHK(ack, 1'b1)
    u_master.stop();
    // Single conversion trigger, refused outside standby
    wr(8'h03, 8'h00, 1'b1);
    shots = 0;
    wr(8'h0F, 8'hA5, 1'b1);
    wr(8'h03, 8'h40, 1'b1);
    `CHK(standby, 1'b1)
    `CHK(configOut, 8'h40)
    wr(8'h0F, 8'hA5, 1'b1);
    `CHK(shots, 1)
    rd(8'h0F, 1'b1, d);
    `CHK(d, 8'h00)
    // Clock parked low while the port drives a zero
    setRd({10'h064, 13'h0, 13'h0, 3'h0}, 1'b0);
    wr(8'h10, 8'h00, 1'b0);
    u_master.start();
    u_master.put({`TSRP_SLAVE_ADDR, 1'b1}, ack);
    u_master.hold(100);
    `CHK(sdaLine, 1'b1)
    u_master.stop();
    rd(8'h00, 1'b0, d);
    `CHK(d, 8'h19)
    complete_run();
  end
endmodule : tsrp_port_tb

//--- bench/tsrp_smbus_master.sv
// Bus master model that drives the serial clock and data lines
module tsrp_smbus_master (
  // Link clock and wire level
  input wire logic sclClk,
  input wire logic sdaLine,
  // Master drive, clock is push-pull, data pulls low only
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic bitIo(input logic b, output logic r);
    @(posedge sclClk) sdaLow = !b;
    @(posedge sclClk) scl = 1'b1;
    @(posedge sclClk) r = sdaLine;
    @(posedge sclClk) scl = 1'b0;
  endtask : bitIo

  task automatic start();
    @(posedge sclClk) sdaLow = 1'b0;
    @(posedge sclClk) scl = 1'b1;
    @(posedge sclClk) sdaLow = 1'b1;
    @(posedge sclClk) scl = 1'b0;
  endtask : start

  task automatic stop();
    @(posedge sclClk) sdaLow = 1'b1;
    @(posedge sclClk) scl = 1'b1;
    @(posedge sclClk) sdaLow = 1'b0;
  endtask : stop

  // byte out, then the ack slot
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, ack);
  endtask : put

  // byte in, then ack or nack
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(nack, r);
  endtask : get

  // clock parked low to force a bus timeout
  task automatic hold(input int n);
    repeat (n) @(posedge sclClk);
  endtask : hold
endmodule : tsrp_smbus_master

//--- core/tsrp_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TSRP_CONSTS_SVH
`define TSRP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TSRP_REG_STATUS 8'h02
`define TSRP_REG_CONFIG 8'h03
`define TSRP_REG_FILTER 8'h06
`define TSRP_REG_ONESHOT 8'h0F
`define TSRP_REG_LOC_HI 8'h10
`define TSRP_REG_R1_HI 8'h11
`define TSRP_REG_R2_HI 8'h12
`define TSRP_REG_LOC_LO 8'h20
`define TSRP_REG_R1_LO 8'h21
`define TSRP_REG_R2_LO 8'h22
`define TSRP_REG_MFG_ID 8'hFE
`define TSRP_REG_REV_ID 8'hFF

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define TSRP_POINTER_RST 8'h00
`define TSRP_CONFIG_RST 8'h00
`define TSRP_FILTER_RST 8'h05
// Arbitrary neutral identity values
`define TSRP_MFG_ID_VAL 8'h5A
`define TSRP_REV_ID_VAL 8'h11
// Arbitrary internal slave address
`define TSRP_SLAVE_ADDR 7'h2B
`define TSRP_CFG_STANDBY 6
`define TSRP_CFG_UNSIGNED_R1 3
`define TSRP_CFG_UNSIGNED_R2 4
`define TSRP_FLT_R1 0
`define TSRP_FLT_R2 2
`define TSRP_STS_BUSY 7
`define TSRP_STS_R2_MISSING 1
`define TSRP_STS_R1_MISSING 0
`define TSRP_LOCAL_MAX 10'h1FF
`define TSRP_FAULT_SIGNED 13'h1000
`define TSRP_FAULT_UNSIGNED 13'h1FFC

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TSRP_CLK_NS 10
`define TSRP_TIMEOUT_MS 35
`define TSRP_TIMEOUT_CYC ((`TSRP_TIMEOUT_MS * 1000000) / `TSRP_CLK_NS)

`endif

//--- core/tsrp_pkg.sv
// Types shared by the sensor register port
package tsrp_pkg;

  typedef struct packed {
    logic [9:0] local10;
    logic [12:0] remote1;
    logic [12:0] remote2;
    logic remote1Fault;
    logic remote2Fault;
    logic localOver;
  } tsrp_readings_t;

  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } tsrp_bus_in_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } tsrp_state_t;

endpackage : tsrp_pkg

//--- core/tsrp_port.sv
// Serial slave port and register file of a three-channel sensor
//
// Notes on behaviour
// - Slave only: clock line is input, never driven or stretched.
// - Responds to one fixed internal 7-bit address.
// - Remote unfiltered reading is 11 bits, signed or unsigned, 0.125C step.
// - Remote filtered reading is 13 bits, signed or unsigned, 1/32C step.
// - Values left-aligned in 16 bits over high and low byte, rest zero.
// - Local reading is 10-bit two's complement with 0.25C step.
// - Local reading saturates at +127.75C, never wraps negative.
// - Faulted diode reads -128.000C signed or +255.875C unsigned.
// - Diode fault sets missing flag, bit 1 channel two, bit 0 one.
// - Pointer holds 00 after reset, selecting local high byte.
// - Pointer keeps last written value across transactions.
// - Read with pointer preset is address byte then data byte.
// - Transmitted bytes go out most significant bit first.
// - Master ack or nack accepted; nack ends the read.
// - Remote high byte read freezes low byte until low byte read.
// - Each further high byte read refreshes the frozen low byte.
// - Clock or data low over 35ms returns the port to idle.
// - Start anywhere aborts transfer; an address byte follows.
// - One-shot write in standby runs one conversion, then standby.
// - One-shot data discarded; that location reads zero.
// - Busy bit 7 of status is high only while converting.
// - One-shot acts only in standby and converts all channels.
`include "tsrp_consts.svh"

module tsrp_port #(
  parameter int TIMEOUT_CYC = `TSRP_TIMEOUT_CYC
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link clock and pins
  input wire logic sclClk,
  input wire tsrp_pkg::tsrp_bus_in_t busIn,
  output logic sdaOut,
  output logic sdaOe,
  // Conversion engine
  input wire tsrp_pkg::tsrp_readings_t readings,
  input wire logic readingsStrobe,
  input wire logic converting,
  output logic standby,
  output logic oneShotGo,
  output logic [7:0] configOut,
  output logic [7:0] filterOut
);

  // --------------------------------------------------------------------
  // Pin synchronisers on system clock
  // --------------------------------------------------------------------
  // slave only
  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic sclLvl;
  logic sdaLvl;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclLvl <= 1'b1;
      sdaLvl <= 1'b1;
    end else begin
      sclSync <= {sclSync[1:0], busIn.sclIn};
      sdaSync <= {sdaSync[1:0], busIn.sdaIn};
      if (sclSync[1] == sclSync[2]) sclLvl <= sclSync[2];
      if (sdaSync[1] == sdaSync[2]) sdaLvl <= sdaSync[2];
    end
  end

  wire sclRise = sclSync[2] & (sclSync[1] == sclSync[2]) & ~sclLvl;
  wire sclFall = ~sclSync[2] & (sclSync[1] == sclSync[2]) & sclLvl;
  wire sdaNew = sdaSync[2] & (sdaSync[1] == sdaSync[2]);
  wire sdaChg = (sdaSync[1] == sdaSync[2]) & (sdaNew != sdaLvl);
  // Data moving while clock high marks start or stop
  wire startCond = sdaChg & ~sdaNew & sclLvl;
  wire stopCond = sdaChg & sdaNew & sclLvl;

  // --------------------------------------------------------------------
  // Bus timeout
  // --------------------------------------------------------------------
  // One count per line: a byte of zeros keeps some line low all along,
  // so only a line stuck low by itself may time out
  logic [31:0] sclLowCount;
  logic [31:0] sdaLowCount;
  logic timeoutHit;
  wire [31:0] next_sclLowCount = sclLvl ? 32'h0 : sclLowCount + 32'h1;
  wire [31:0] next_sdaLowCount = sdaLvl ? 32'h0 : sdaLowCount + 32'h1;
  wire sclStuck = ~sclLvl && (sclLowCount == 32'(TIMEOUT_CYC));
  wire sdaStuck = ~sdaLvl && (sdaLowCount == 32'(TIMEOUT_CYC));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclLowCount <= 32'h0;
      sdaLowCount <= 32'h0;
      timeoutHit <= 1'b0;
    end else begin
      sclLowCount <= next_sclLowCount;
      sdaLowCount <= next_sdaLowCount;
      timeoutHit <= sclStuck | sdaStuck;
    end
  end

  // --------------------------------------------------------------------
  // Serial state machine
  // --------------------------------------------------------------------
  tsrp_pkg::tsrp_state_t state;
  logic [7:0] shiftReg;
  logic [2:0] bitCnt;
  logic isRead;
  logic gotCmd;
  logic [7:0] pointer;
  logic [7:0] txByte;

  wire byteDone = sclRise && (bitCnt == 3'h7);
  wire [7:0] rxByte = {shiftReg[6:0], sdaLvl};
  wire addrMatch = (rxByte[7:1] == `TSRP_SLAVE_ADDR);
  wire abort = startCond | stopCond | timeoutHit;
  // Ack slot ends at the fall after its own rise, counted as bit one
  wire ackEnd = sclFall && (bitCnt == 3'h1);
  wire writeData = byteDone && (state == tsrp_pkg::ST_WRITE) && gotCmd;
  wire writeCmd = byteDone && (state == tsrp_pkg::ST_WRITE) && !gotCmd;
  wire readFetch = ackEnd &&
    ((state == tsrp_pkg::ST_ADDR_ACK && isRead) ||
     (state == tsrp_pkg::ST_READ_ACK && !sdaLvl));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= tsrp_pkg::ST_IDLE;
      shiftReg <= 8'h00;
      bitCnt <= 3'h0;
      isRead <= 1'b0;
      gotCmd <= 1'b0;
    end else if (startCond) begin
      state <= tsrp_pkg::ST_ADDR;
      bitCnt <= 3'h0;
    end else if (abort) begin
      state <= tsrp_pkg::ST_IDLE;
    end else begin
      if (sclRise) begin
        shiftReg <= rxByte;
        bitCnt <= bitCnt + 3'h1;
      end
      unique case (state)
        tsrp_pkg::ST_IDLE: begin
        end
        tsrp_pkg::ST_ADDR: begin
          if (byteDone) begin
            isRead <= rxByte[0];
            gotCmd <= 1'b0;
            state <= addrMatch ? tsrp_pkg::ST_ADDR_ACK : tsrp_pkg::ST_IDLE;
          end
        end
        tsrp_pkg::ST_ADDR_ACK: begin
          if (ackEnd) begin
            state <= isRead ? tsrp_pkg::ST_READ : tsrp_pkg::ST_WRITE;
            bitCnt <= 3'h0;
          end
        end
        tsrp_pkg::ST_WRITE: begin
          if (byteDone) begin
            state <= tsrp_pkg::ST_WRITE_ACK;
          end
        end
        tsrp_pkg::ST_WRITE_ACK: begin
          if (ackEnd) begin
            gotCmd <= 1'b1;
            state <= tsrp_pkg::ST_WRITE;
            bitCnt <= 3'h0;
          end
        end
        tsrp_pkg::ST_READ: begin
          if (byteDone) begin
            state <= tsrp_pkg::ST_READ_ACK;
          end
        end
        tsrp_pkg::ST_READ_ACK: begin
          if (sclRise && sdaLvl) begin
            state <= tsrp_pkg::ST_IDLE;
          end else if (ackEnd) begin
            state <= tsrp_pkg::ST_READ;
            bitCnt <= 3'h0;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] cfgReg;
  logic [7:0] filter;
  tsrp_pkg::tsrp_readings_t held;
  logic oneShotReq;
  logic [7:0] r1LoLock;
  logic [7:0] r2LoLock;
  logic r1Locked;
  logic r2Locked;
  logic [7:0] status;

  wire [7:0] next_pointer = writeCmd ? rxByte : pointer;
  wire ptrIsOneShot = (pointer == `TSRP_REG_ONESHOT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= `TSRP_POINTER_RST;
      cfgReg <= `TSRP_CONFIG_RST;
      filter <= `TSRP_FILTER_RST;
      oneShotReq <= 1'b0;
    end else begin
      pointer <= next_pointer;
      if (writeData && pointer == `TSRP_REG_CONFIG) cfgReg <= rxByte;
      if (writeData && pointer == `TSRP_REG_FILTER) filter <= rxByte;
      oneShotReq <= writeData && ptrIsOneShot &&
                    cfgReg[`TSRP_CFG_STANDBY];
    end
  end

  // Readings held per conversion, so high and low bytes share one result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else if (readingsStrobe) begin
      held <= readings;
    end
  end

  // --------------------------------------------------------------------
  // Temperature formatting
  // --------------------------------------------------------------------
  function automatic logic [15:0] fmtRemote(input logic [12:0] raw,
                                            input logic filt,
                                            input logic unsignedMode,
                                            input logic fault);
    logic [12:0] v;
    v = raw;
    if (fault) begin
      v = unsignedMode ? `TSRP_FAULT_UNSIGNED : `TSRP_FAULT_SIGNED;
    end
    if (filt) begin
      fmtRemote = {v, 3'h0};
    end else begin
      fmtRemote = {v[12:2], 5'h00};
    end
  endfunction : fmtRemote

  wire [9:0] localSat = held.localOver ? `TSRP_LOCAL_MAX
                                       : held.local10;
  wire [15:0] localWord = {localSat, 6'h00};
  wire [15:0] r1Word = fmtRemote(held.remote1,
    filter[`TSRP_FLT_R1], cfgReg[`TSRP_CFG_UNSIGNED_R1],
    held.remote1Fault);
  wire [15:0] r2Word = fmtRemote(held.remote2,
    filter[`TSRP_FLT_R2], cfgReg[`TSRP_CFG_UNSIGNED_R2],
    held.remote2Fault);

  wire [7:0] next_status = {converting, 5'h00,
                            held.remote2Fault, held.remote1Fault};

  wire hiRead = readFetch;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r1LoLock <= 8'h00;
      r2LoLock <= 8'h00;
      r1Locked <= 1'b0;
      r2Locked <= 1'b0;
      status <= 8'h00;
    end else begin
      status <= next_status;
      if (hiRead && pointer == `TSRP_REG_R1_HI) begin
        r1LoLock <= r1Word[7:0];
        r1Locked <= 1'b1;
      end else if (hiRead && pointer == `TSRP_REG_R1_LO) begin
        r1Locked <= 1'b0;
      end
      if (hiRead && pointer == `TSRP_REG_R2_HI) begin
        r2LoLock <= r2Word[7:0];
        r2Locked <= 1'b1;
      end else if (hiRead && pointer == `TSRP_REG_R2_LO) begin
        r2Locked <= 1'b0;
      end
    end
  end

  wire [7:0] r1Lo = r1Locked ? r1LoLock : r1Word[7:0];
  wire [7:0] r2Lo = r2Locked ? r2LoLock : r2Word[7:0];

  logic [7:0] readMux;
  always_comb begin
    unique case (pointer)
      `TSRP_REG_STATUS: readMux = status;
      // power-up location is the local high byte
      `TSRP_POINTER_RST: readMux = localWord[15:8];
      `TSRP_REG_CONFIG: readMux = cfgReg;
      `TSRP_REG_FILTER: readMux = filter;
      `TSRP_REG_LOC_HI: readMux = localWord[15:8];
      `TSRP_REG_R1_HI: readMux = r1Word[15:8];
      `TSRP_REG_R2_HI: readMux = r2Word[15:8];
      `TSRP_REG_LOC_LO: readMux = localWord[7:0];
      `TSRP_REG_R1_LO: readMux = r1Lo;
      `TSRP_REG_R2_LO: readMux = r2Lo;
      `TSRP_REG_MFG_ID: readMux = `TSRP_MFG_ID_VAL;
      `TSRP_REG_REV_ID: readMux = `TSRP_REV_ID_VAL;
      default: readMux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Data line drive
  // --------------------------------------------------------------------
  // Drive changes only on falling clock or on abort, so data is stable while high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txByte <= 8'h00;
      sdaOe <= 1'b0;
    end else if (abort) begin
      sdaOe <= 1'b0;
    end else if (sclFall) begin
      if (state == tsrp_pkg::ST_ADDR_ACK && bitCnt == 3'h0) begin
        sdaOe <= 1'b1;
      end else if (state == tsrp_pkg::ST_WRITE_ACK && bitCnt == 3'h0) begin
        sdaOe <= 1'b1;
      end else if (readFetch) begin
        txByte <= {readMux[6:0], 1'b0};
        sdaOe <= ~readMux[7];
      end else if (state == tsrp_pkg::ST_READ && bitCnt != 3'h0) begin
        txByte <= {txByte[6:0], 1'b0};
        sdaOe <= ~txByte[7];
      end else begin
        sdaOe <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOut <= 1'b0;
      standby <= 1'b0;
      oneShotGo <= 1'b0;
      configOut <= `TSRP_CONFIG_RST;
      filterOut <= `TSRP_FILTER_RST;
    end else begin
      sdaOut <= 1'b0;
      standby <= cfgReg[`TSRP_CFG_STANDBY];
      oneShotGo <= oneShotReq;
      configOut <= cfgReg;
      filterOut <= filter;
    end
  end

  // sclClk is kept for the link; bus sampling is oversampled on clk
  logic sclSeen;
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) sclSeen <= 1'b0;
    else sclSeen <= 1'b1;
  end

endmodule : tsrp_port
